/* File: common/twi_defines.svh */
// Offsets, field positions, reset values and status codes of the
// two-wire controller. Assumes inclusion by bare name in design files.
`ifndef TWI_DEFINES_SVH
`define TWI_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets on the processor port
// ----------------------------------------------------------------
`define OWN_ADDR_OFS 8'hC8
`define EXT_ADDR_OFS 8'hC9
`define BYTE_BUF_OFS 8'hCA
`define SETTINGS_OFS 8'hCB
`define STATE_CODE_OFS 8'hCC
`define SOFT_RESTART_OFS 8'hCD

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GC_ENABLE_BIT 0
`define IRQ_ENABLE_BIT 7
`define BUS_ENABLE_BIT 6
`define BEGIN_REQ_BIT 5
`define HALT_REQ_BIT 4
`define ATTN_BIT 3
`define ACK_BIT 2
`define TEN_PREFIX 5'h1E

// ----------------------------------------------------------------
// Reset values and status codes
// ----------------------------------------------------------------
`define REG_RESET 8'h00
`define CODE_IDLE 8'hF8
`define CODE_OWN_W 8'h60
`define CODE_GC_W 8'h70
`define CODE_RX_ACK 8'h80
`define CODE_RX_NACK 8'h88
`define CODE_GC_RX_ACK 8'h90
`define CODE_GC_RX_NACK 8'h98
`define CODE_STOP 8'hA0
`define CODE_OWN_R 8'hA8
`define CODE_TX_ACK 8'hB8
`define CODE_TX_NACK 8'hC0
`define CODE_TX_LAST 8'hC8

// ----------------------------------------------------------------
// Receive buffer shape
// ----------------------------------------------------------------
`define RX_FIFO_WIDTH 8
`define RX_FIFO_DEPTH 32

`endif

/* File: common/twi_pkg.sv */
// Types shared by the two-wire controller and its test bench.
// Assumes nothing of its surroundings.
`default_nettype none

package twi_pkg;

	// Bus engine states
	typedef enum logic [2:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_ADDR2,
		BUS_ADDR_ACK,
		BUS_RX,
		BUS_RX_ACK,
		BUS_TX,
		BUS_TX_ACK
	} bus_state_t;

	// One processor access, strobes one cycle wide
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} cpu_req_t;

	// Open-drain drive of the two bus wires, enables active low
	typedef struct packed {
		logic scl_out;
		logic scl_oe_n;
		logic sda_out;
		logic sda_oe_n;
	} pin_drive_t;

endpackage

`default_nettype wire

/* File: rtl/rx_fifo.sv */
// Flop-based FIFO holding received bus bytes.
// Assumes one clock, a clock enable, and valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module rx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Filling side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Draining side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];  // Storage
	logic [AW-1:0] wr_ptr;  // Next slot to fill
	logic [AW-1:0] rd_ptr;  // Oldest entry
	logic [AW:0] count;  // Entries held

	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	// Storage is written only on an accepted push
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (ce) begin
			if (push) begin
				wr_ptr <= AW'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= AW'(rd_ptr + 1'b1);
			end
			count <= (AW+1)'(count + push - pop);
		end
	end
endmodule

`default_nettype wire

/* File: rtl/twi_slave_ctrl.sv */
// Two-wire bus controller: processor registers, resets and own-address
// recognition with a slave byte engine. Assumes bus wires from pins,
// open-drain pads outside, and a processor giving one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
`include "twi_defines.svh"

module twi_slave_ctrl
	import twi_pkg::*;
(
	// Clock, reset and freeze
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	// Processor register port
	input wire cpu_req_t cpu_req,
	output logic [7:0] cpu_rdata,
	// Bus wires
	input wire logic scl_in,
	input wire logic sda_in,
	output pin_drive_t pins,
	// Clock divider setting for the master side
	output logic [7:0] rate_setting
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0] own_bus_address;  // Own address and broadcast enable
	logic [7:0] extended_own_address;  // Low byte of ten-bit address
	logic [7:0] byte_buffer;  // Byte to send
	logic [7:0] controller_settings;  // Enables and requests
	logic [7:0] bus_state_code;  // Status code
	logic [2:0] scl_s;  // Clock synchroniser
	logic [2:0] sda_s;  // Data synchroniser
	logic scl_q;  // Filtered clock level
	logic sda_q;  // Filtered data level
	bus_state_t state;  // Engine state
	bus_state_t resume;  // State after an ack bit
	logic [7:0] shreg;  // Incoming bits
	logic [3:0] bitcnt;  // Bits seen in this byte
	logic [1:0] ten_hi;  // High bits of a ten-bit head byte
	logic ten_sel;  // Selected by full ten-bit address
	logic gc_mode;  // Entered via general call
	logic drive_ack;  // Pull data low in the ack bit
	logic [7:0] fifo_head;
	logic fifo_valid;
	logic fifo_ready;

	// Address decode for the register port
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// ----------------------------------------------------------------
	// Register port decode
	// ----------------------------------------------------------------
	wire wr_own = cpu_req.wr && hit(cpu_req.addr, `OWN_ADDR_OFS);
	wire wr_ext = cpu_req.wr && hit(cpu_req.addr, `EXT_ADDR_OFS);
	wire wr_buf = cpu_req.wr && hit(cpu_req.addr, `BYTE_BUF_OFS);
	wire wr_set = cpu_req.wr && hit(cpu_req.addr, `SETTINGS_OFS);
	wire wr_rate = cpu_req.wr && hit(cpu_req.addr, `STATE_CODE_OFS);
	wire wr_srr = cpu_req.wr && hit(cpu_req.addr, `SOFT_RESTART_OFS);
	wire rd_buf = cpu_req.rd && hit(cpu_req.addr, `BYTE_BUF_OFS);
	// Received bytes take priority over the send byte on read
	wire [7:0] buf_view = fifo_valid ? fifo_head : byte_buffer;
	// read map, write-only ones read zero
	wire [7:0] next_rdata =
		hit(cpu_req.addr, `OWN_ADDR_OFS) ? own_bus_address :
		hit(cpu_req.addr, `EXT_ADDR_OFS) ? extended_own_address :
		hit(cpu_req.addr, `BYTE_BUF_OFS) ? buf_view :
		hit(cpu_req.addr, `SETTINGS_OFS) ? controller_settings :
		hit(cpu_req.addr, `STATE_CODE_OFS) ? bus_state_code : 8'h00;

	// ----------------------------------------------------------------
	// Bus edge detection
	// ----------------------------------------------------------------
	// A change counts once the second and third stages agree
	wire scl_ok = (scl_s[1] == scl_s[2]);
	wire sda_ok = (sda_s[1] == sda_s[2]);
	wire scl_rise = scl_ok && scl_s[2] && !scl_q;
	wire scl_fall = scl_ok && !scl_s[2] && scl_q;
	wire sda_rise = sda_ok && sda_s[2] && !sda_q;
	wire sda_fall = sda_ok && !sda_s[2] && sda_q;
	wire start_det = sda_fall && scl_q && !scl_fall;
	wire stop_det = sda_rise && scl_q && !scl_fall;

	// ----------------------------------------------------------------
	// Address matching
	// ----------------------------------------------------------------
	wire bus_on = controller_settings[`BUS_ENABLE_BIT];
	wire ack_en = controller_settings[`ACK_BIT];
	wire byte_full = (bitcnt == 4'h8);
	wire byte_end = scl_fall && byte_full;
	// reserved prefix means ten-bit own address
	wire ten_mode = (own_bus_address[7:3] == `TEN_PREFIX);
	// all seven bits compared, any value without the ten-bit prefix
	wire hit7 = !ten_mode && (shreg[7:1] == own_bus_address[7:1]);
	wire gc_hit = (shreg == 8'h00) && own_bus_address[`GC_ENABLE_BIT];
	wire head_hit = ten_mode && (shreg[7:1] == {`TEN_PREFIX, own_bus_address[2:1]});
	wire [9:0] ten_own = {own_bus_address[2:1], extended_own_address};
	wire ten_hit = ({ten_hi, shreg} == ten_own);
	wire sel7 = ack_en && hit7;
	wire sel_gc = ack_en && gc_hit && !hit7;
	wire head_w = ack_en && head_hit && !shreg[0];
	wire head_r = ack_en && head_hit && shreg[0] && ten_sel;
	wire [7:0] sel_code = sel_gc ? `CODE_GC_W : (shreg[0] ? `CODE_OWN_R : `CODE_OWN_W);
	wire rx_ok = ack_en && fifo_ready;
	wire [7:0] rx_code = gc_mode ? (rx_ok ? `CODE_GC_RX_ACK : `CODE_GC_RX_NACK)
		: (rx_ok ? `CODE_RX_ACK : `CODE_RX_NACK);
	// Halt request in slave operation acts as a received STOP
	wire halt_now = controller_settings[`HALT_REQ_BIT] && state != BUS_IDLE;
	wire rx_side = (state == BUS_RX) || (state == BUS_RX_ACK);
	wire abort = stop_det || halt_now || !bus_on;

	// Hardware events that raise a status code and the attention flag
	logic flag_set;
	logic [7:0] new_code;
	always_comb begin
		flag_set = 1'b0;
		new_code = bus_state_code;
		if (!ce || wr_srr || !bus_on) begin
			flag_set = 1'b0;
		end else if ((stop_det || start_det) && rx_side) begin
			flag_set = 1'b1;
			new_code = `CODE_STOP;
		end else if (byte_end && state == BUS_ADDR && (sel7 || sel_gc || head_r)) begin
			// own address or broadcast selects slave
			flag_set = 1'b1;
			new_code = head_r ? `CODE_OWN_R : sel_code;
		end else if (byte_end && state == BUS_ADDR2 && ack_en && ten_hit) begin
			// flag only after the second byte
			flag_set = 1'b1;
			new_code = `CODE_OWN_W;
		end else if (byte_end && state == BUS_RX) begin
			flag_set = 1'b1;
			new_code = rx_code;
		end else if (scl_rise && state == BUS_TX_ACK) begin
			flag_set = 1'b1;
			new_code = sda_q ? `CODE_TX_NACK : (ack_en ? `CODE_TX_ACK : `CODE_TX_LAST);
		end
	end

	// Output drive values
	wire stretch = state != BUS_IDLE && !scl_q &&
		(controller_settings[`ATTN_BIT] || (state == BUS_RX && !fifo_ready));
	wire tx_bit = byte_buffer[3'd7 - bitcnt[2:0]];
	wire next_sda_oe_n = (state == BUS_TX && !byte_full) ? tx_bit : !drive_ack;

	// ----------------------------------------------------------------
	// Synchronisers
	// ----------------------------------------------------------------
	// Three stages; only the second reads the first
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
		end else if (ce) begin
			scl_s <= {scl_s[1:0], scl_in};
			sda_s <= {sda_s[1:0], sda_in};
		end
	end

	// Filtered levels follow agreed stages
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce) begin
			scl_q <= scl_ok ? scl_s[2] : scl_q;
			sda_q <= sda_ok ? sda_s[2] : sda_q;
		end
	end

	// ----------------------------------------------------------------
	// Processor registers
	// ----------------------------------------------------------------
	// Address, extended address, send byte and divider
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			own_bus_address <= `REG_RESET;
			extended_own_address <= `REG_RESET;
			byte_buffer <= `REG_RESET;
			rate_setting <= `REG_RESET;
		end else if (ce) begin
			own_bus_address <= wr_own ? cpu_req.wdata : own_bus_address;
			extended_own_address <= wr_ext ? cpu_req.wdata : extended_own_address;
			byte_buffer <= wr_buf ? cpu_req.wdata : byte_buffer;
			rate_setting <= wr_rate ? cpu_req.wdata : rate_setting;
		end
	end

	// Settings: requests only set by software, attention set wins
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			controller_settings <= `REG_RESET;
		end else if (ce) begin
			if (wr_srr) begin
				controller_settings <= controller_settings & 8'hC7;
			end else begin
				controller_settings[7:6] <= wr_set ? cpu_req.wdata[7:6] : controller_settings[7:6];
				controller_settings[2:0] <= wr_set ? cpu_req.wdata[2:0] : controller_settings[2:0];
				controller_settings[`BEGIN_REQ_BIT] <= controller_settings[`BEGIN_REQ_BIT] ||
					(wr_set && cpu_req.wdata[`BEGIN_REQ_BIT]);
				controller_settings[`HALT_REQ_BIT] <= !halt_now &&
					(controller_settings[`HALT_REQ_BIT] || (wr_set && cpu_req.wdata[`HALT_REQ_BIT]));
				controller_settings[`ATTN_BIT] <= flag_set || (wr_set ?
					cpu_req.wdata[`ATTN_BIT] && controller_settings[`ATTN_BIT] :
					controller_settings[`ATTN_BIT]);
			end
		end
	end

	// Status code and read data
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_state_code <= `CODE_IDLE;
			cpu_rdata <= 8'h00;
		end else if (ce) begin
			bus_state_code <= wr_srr ? `CODE_IDLE : new_code;
			cpu_rdata <= cpu_req.rd ? next_rdata : cpu_rdata;
		end
	end

	// ----------------------------------------------------------------
	// Bus byte engine
	// ----------------------------------------------------------------
	// Shift, count and step through address, ack and data phases
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= BUS_IDLE;
			resume <= BUS_IDLE;
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			ten_hi <= 2'h0;
			ten_sel <= 1'b0;
			gc_mode <= 1'b0;
			drive_ack <= 1'b0;
		end else if (ce) begin
			if (wr_srr || abort) begin
				state <= BUS_IDLE;
				drive_ack <= 1'b0;
				ten_sel <= 1'b0;
			end else if (start_det) begin
				state <= BUS_ADDR;
				bitcnt <= 4'h0;
				drive_ack <= 1'b0;
			end else if (scl_rise && !byte_full &&
				(state == BUS_ADDR || state == BUS_ADDR2 || state == BUS_RX)) begin
				// first bit lands in bit 7
				shreg <= {shreg[6:0], sda_q};
				bitcnt <= 4'(bitcnt + 1'b1);
			end else if (scl_rise && state == BUS_TX_ACK && (sda_q || !ack_en)) begin
				state <= BUS_IDLE;
			end else if (byte_end && state == BUS_ADDR) begin
				bitcnt <= 4'h0;
				drive_ack <= sel7 || sel_gc || head_w || head_r;
				state <= (sel7 || sel_gc || head_w || head_r) ? BUS_ADDR_ACK : BUS_IDLE;
				ten_hi <= shreg[2:1];
				gc_mode <= sel_gc;
				// head byte acked quietly, wait for the second
				resume <= head_w ? BUS_ADDR2 : (shreg[0] ? BUS_TX : BUS_RX);
			end else if (byte_end && state == BUS_ADDR2) begin
				bitcnt <= 4'h0;
				drive_ack <= ack_en && ten_hit;
				ten_sel <= ack_en && ten_hit;
				state <= (ack_en && ten_hit) ? BUS_ADDR_ACK : BUS_IDLE;
				resume <= BUS_RX;
			end else if (byte_end && state == BUS_RX) begin
				bitcnt <= 4'h0;
				drive_ack <= rx_ok;
				state <= BUS_RX_ACK;
				resume <= rx_ok ? BUS_RX : BUS_IDLE;
			end else if (scl_fall && (state == BUS_ADDR_ACK || state == BUS_RX_ACK)) begin
				drive_ack <= 1'b0;
				state <= resume;
			end else if (scl_fall && state == BUS_TX) begin
				bitcnt <= 4'(bitcnt + 1'b1);
				state <= (bitcnt == 4'h7) ? BUS_TX_ACK : BUS_TX;
			end else if (scl_fall && state == BUS_TX_ACK) begin
				bitcnt <= 4'h0;
				state <= BUS_TX;
			end
		end
	end

	// Registered pad drive; wires are only ever pulled low
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pins <= '{scl_out: 1'b0, scl_oe_n: 1'b1, sda_out: 1'b0, sda_oe_n: 1'b1};
		end else if (ce) begin
			pins.scl_oe_n <= !stretch;
			pins.sda_oe_n <= next_sda_oe_n;
		end
	end

	// ----------------------------------------------------------------
	// Receive buffer
	// ----------------------------------------------------------------
	// Full buffer stretches the clock and refuses the byte
	rx_fifo #(
		.WIDTH(`RX_FIFO_WIDTH),
		.DEPTH(`RX_FIFO_DEPTH)
	) u_rx_fifo (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.in_data(shreg),
		.in_valid(byte_end && state == BUS_RX && bus_on && !wr_srr && !stop_det),
		.in_ready(fifo_ready),
		.out_data(fifo_head),
		.out_valid(fifo_valid),
		.out_ready(rd_buf && ce)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence srr_seq;
		ce && wr_srr;
	endsequence
	sequence ack_seq;
		drive_ack ##1 !pins.sda_oe_n;
	endsequence
	wire addr_end = ce && byte_end && state == BUS_ADDR && bus_on && !wr_srr && !abort;

	own_addr_write_a:
		assert property (ce && wr_own |=> own_bus_address == $past(cpu_req.wdata))
		else $error("own address write lost");
	soft_reset_idle_a:
		assert property (srr_seq |=> state == BUS_IDLE && bus_state_code == `CODE_IDLE)
		else $error("soft reset did not idle");
	soft_reset_bits_a:
		assert property (srr_seq |=> controller_settings[5:3] == 3'h0)
		else $error("soft reset left request bits");
	own_seven_ack_a:
		assert property (addr_end && !ten_mode && ack_en &&
			shreg[7:1] == own_bus_address[7:1] |=> ack_seq)
		else $error("own address not acked");
	ten_head_quiet_a:
		assert property (addr_end && head_w && !wr_set |=>
			drive_ack && state == BUS_ADDR_ACK &&
			controller_settings[`ATTN_BIT] == $past(controller_settings[`ATTN_BIT]))
		else $error("ten-bit head byte raised flag");
	ten_second_a:
		assert property (ce && byte_end && state == BUS_ADDR2 && ack_en && ten_hit &&
			bus_on && !wr_srr && !abort |=>
			controller_settings[`ATTN_BIT] && bus_state_code == `CODE_OWN_W)
		else $error("second byte match missed");
	gc_off_a:
		assert property (addr_end && shreg == 8'h00 && !own_bus_address[0] &&
			!ten_mode && own_bus_address[7:1] != 7'h00 |=> !drive_ack)
		else $error("broadcast acked while disabled");
	gc_receive_a:
		assert property (addr_end && ack_en && shreg == 8'h00 && own_bus_address[0] &&
			!hit7 |=> bus_state_code == `CODE_GC_W && resume == BUS_RX)
		else $error("broadcast did not enter receive");
endmodule

`default_nettype wire

/* File: test/twi_bus_master.sv */
// Behavioural bus master that clocks bytes into the slave.
// Assumes pull-ups on both wires and the resolved levels fed back.
`timescale 1ns/1ps
`default_nettype none

module twi_bus_master (
	// Timing reference
	input wire logic clk,
	// Resolved wire levels
	input wire logic scl,
	input wire logic sda,
	// Pulls, low drives the wire low
	output logic scl_oe_n,
	output logic sda_oe_n
);
	// ----
	// Wire handling
	// ----
	// Idle: both wires released
	initial begin
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
	end

	// Wait whole system cycles
	task automatic ticks(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Stretching by the slave holds the clock low; bounded wait
	task automatic wait_scl();
		int k;
		k = 0;
		while (scl !== 1'b1 && k < 4000) begin
			@(negedge clk);
			k++;
		end
	endtask

	// One clock pulse, 6 low and 2 high; low is long enough that a
	// stretch from the slave starts before we let go
	task automatic pulse(input logic v, output logic got);
		int k;
		k = 0;
		ticks(2);
		sda_oe_n = v;
		// A late ack release by the slave delays our bit
		while (sda !== v && k < 20) begin
			@(negedge clk);
			k++;
		end
		ticks(4);
		scl_oe_n = 1'b1;
		wait_scl();
		ticks(2);
		got = sda;
		scl_oe_n = 1'b0;
	endtask

	// ----
	// Frame pieces
	// ----
	// Data falls while the clock is high
	task automatic start();
		ticks(4);
		sda_oe_n = 1'b0;
		ticks(4);
		scl_oe_n = 1'b0;
	endtask

	// Data rises while the clock is high
	task automatic stop();
		sda_oe_n = 1'b0;
		ticks(3);
		scl_oe_n = 1'b1;
		wait_scl();
		ticks(4);
		sda_oe_n = 1'b1;
		ticks(4);
	endtask

	// Eight bits msb first, then the answer slot
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic unused;
		for (int i = 7; i >= 0; i--) begin
			pulse(b[i], unused);
		end
		pulse(1'b1, ack);
	endtask
endmodule

`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the two-wire slave controller.
// Assumes the bus master model and open-drain wires with pull-ups.
`timescale 1ns/1ps
`default_nettype none
`include "twi_defines.svh"

module tb
	import twi_pkg::*;
;
	logic clk, arst_n, ce, scl, sda, m_scl_oe_n, m_sda_oe_n;
	cpu_req_t req;
	logic [7:0] rdata, rate;
	pin_drive_t pins;
	int n_errors, n_tests;

	// A wire is low if any party pulls it
	assign scl = m_scl_oe_n & pins.scl_oe_n;
	assign sda = m_sda_oe_n & pins.sda_oe_n;

	twi_slave_ctrl dut (.clk(clk), .arst_n(arst_n), .ce(ce), .cpu_req(req),
		.cpu_rdata(rdata), .scl_in(scl), .sda_in(sda), .pins(pins), .rate_setting(rate));
	twi_bus_master m (.clk(clk), .scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n),
		.sda_oe_n(m_sda_oe_n));

	always #10 clk = ~clk;

	// ----
	// Shared tasks
	// ----
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		if (n_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// One-cycle strobes, launched on the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge clk);
		req.wr = 1'b0;
	endtask

	// Read strobe only; the value lands in rdata one cycle later
	task automatic rdone(input logic [7:0] a);
		@(negedge clk);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge clk);
		req.rd = 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		rdone(a);
		check(what, rdata, exp);
	endtask

	// Full buffer: the clock stays held until bytes are popped
	task automatic drain();
		int k;
		k = 0;
		// Let the ack clock pass first; the flag stretch is already gone
		while (scl !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
		while (pins.scl_oe_n !== 1'b0 && k < 200) begin
			@(negedge clk);
			k++;
		end
		repeat (20) @(negedge clk);
		check("full stretch", {7'h0, pins.scl_oe_n}, 8'h00);
		for (int i = 0; i < 32; i++) begin
			rdchk(`BYTE_BUF_OFS, 8'(i * 9 + 1), "fifo byte");
		end
		rdchk(`BYTE_BUF_OFS, 8'h5A, "fifo empty");
	endtask

	// Processor answer to a stretch: 1 clear, 2 soft restart, 3 drain
	task automatic serve(input int mode, output logic [7:0] st);
		int k;
		k = 0;
		while (pins.scl_oe_n !== 1'b0 && k < 400) begin
			@(negedge clk);
			k++;
		end
		rdone(`STATE_CODE_OFS);
		st = rdata;
		if (pins.scl_oe_n === 1'b0 && mode == 2) begin
			wr(`SETTINGS_OFS, 8'h6C);
			wr(`SOFT_RESTART_OFS, 8'h5A);
			rdchk(`SETTINGS_OFS, 8'h44, "settings after restart");
			rdchk(`STATE_CODE_OFS, `CODE_IDLE, "code after restart");
			check("stretch freed", {7'h0, pins.scl_oe_n}, 8'h01);
		end else begin
			wr(`SETTINGS_OFS, 8'h44);
			if (mode == 3) drain();
		end
	endtask

	task automatic xfer(input logic [7:0] b, input int mode, output logic [7:0] st,
		output logic ack);
		st = `CODE_IDLE;
		fork
			m.put_byte(b, ack);
			if (mode != 0) serve(mode, st);
		join
	endtask

	// ----
	// Scenarios
	// ----
	task automatic regs_check();
		for (int i = 0; i < 4; i++) begin
			rdchk(8'(`OWN_ADDR_OFS + i), `REG_RESET, "reset value");
		end
		rdchk(`STATE_CODE_OFS, `CODE_IDLE, "idle code");
		wr(`STATE_CODE_OFS, 8'h3C);
		check("divider", rate, 8'h3C);
		rdchk(`STATE_CODE_OFS, `CODE_IDLE, "status read only");
		rdchk(`SOFT_RESTART_OFS, 8'h00, "restart write only");
		for (int i = 0; i < 3; i++) begin
			wr(8'(`OWN_ADDR_OFS + i), 8'(8'hA5 + i));
			rdchk(8'(`OWN_ADDR_OFS + i), 8'(8'hA5 + i), "readback");
		end
		// Clock enable low: the write must not land
		ce = 1'b0;
		wr(`OWN_ADDR_OFS, 8'h11);
		ce = 1'b1;
		rdchk(`OWN_ADDR_OFS, 8'hA5, "frozen write");
		check("pad levels", {6'h0, pins.scl_out, pins.sda_out}, 8'h00);
		wr(`SETTINGS_OFS, 8'hC7);
		rdchk(`SETTINGS_OFS, 8'hC7, "settings");
		wr(`SETTINGS_OFS, 8'h44);
	endtask

	// Mismatch in the first bit only, then a full write frame
	task automatic seven_bit(input logic [6:0] a);
		logic [7:0] st;
		logic ack;
		wr(`OWN_ADDR_OFS, {a, 1'b0});
		m.start();
		xfer({a ^ 7'h40, 1'b0}, 0, st, ack);
		check("first bit nack", {7'h0, ack}, 8'h01);
		m.stop();
		m.start();
		xfer({a, 1'b0}, 1, st, ack);
		check("addr ack", {7'h0, ack}, 8'h00);
		check("own write", st, `CODE_OWN_W);
		xfer(8'h96, 1, st, ack);
		check("rx code", st, `CODE_RX_ACK);
		m.stop();
		rdchk(`BYTE_BUF_OFS, 8'h96, "rx byte");
		wr(`SETTINGS_OFS, 8'h44);
	endtask

	task automatic broadcast();
		logic [7:0] st;
		logic ack;
		wr(`OWN_ADDR_OFS, 8'h23);
		m.start();
		xfer(8'h00, 1, st, ack);
		check("gc ack", {7'h0, ack}, 8'h00);
		check("gc code", st, `CODE_GC_W);
		m.stop();
		wr(`SETTINGS_OFS, 8'h44);
		wr(`OWN_ADDR_OFS, 8'h22);
		m.start();
		xfer(8'h00, 0, st, ack);
		check("gc off", {7'h0, ack}, 8'h01);
		m.stop();
	endtask

	task automatic ten_bit();
		logic [7:0] st;
		logic [7:0] code0;
		logic ack;
		wr(`OWN_ADDR_OFS, 8'hF2);
		wr(`EXT_ADDR_OFS, 8'h3C);
		m.start();
		xfer(8'hF4, 0, st, ack);
		check("upper bits", {7'h0, ack}, 8'h01);
		m.stop();
		wr(`OWN_ADDR_OFS, 8'hF4);
		// The head byte must leave whatever code stands untouched
		rdone(`STATE_CODE_OFS);
		code0 = rdata;
		m.start();
		xfer(8'hF4, 0, st, ack);
		check("first byte ack", {7'h0, ack}, 8'h00);
		rdchk(`SETTINGS_OFS, 8'h44, "no flag");
		rdchk(`STATE_CODE_OFS, code0, "code kept");
		xfer(8'h3C, 1, st, ack);
		check("second ack", {7'h0, ack}, 8'h00);
		check("second code", st, `CODE_OWN_W);
		m.stop();
		wr(`SETTINGS_OFS, 8'h44);
	endtask

	task automatic soft_restart();
		logic [7:0] st;
		logic ack;
		wr(`OWN_ADDR_OFS, 8'h54);
		m.start();
		xfer(8'h54, 2, st, ack);
		check("ack dropped", {7'h0, ack}, 8'h01);
		m.stop();
		rdchk(`STATE_CODE_OFS, `CODE_IDLE, "idle after stop");
	endtask

	task automatic fifo_fill();
		logic [7:0] st;
		logic ack;
		wr(`BYTE_BUF_OFS, 8'h5A);
		m.start();
		xfer(8'h54, 1, st, ack);
		for (int i = 0; i < 32; i++) begin
			xfer(8'(i * 9 + 1), (i == 31) ? 3 : 1, st, ack);
			check("fill code", st, `CODE_RX_ACK);
		end
		m.stop();
		wr(`SETTINGS_OFS, 8'h44);
	endtask

	// Watchdog, well beyond the expected run
	initial begin
		#1_000_000;
		n_errors++;
		test_done();
	end

	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		ce = 1'b1;
		req = '0;
		n_errors = 0;
		n_tests = 0;
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		repeat (3) @(negedge clk);
		regs_check();
		seven_bit(7'h7F);
		seven_bit(7'h01);
		broadcast();
		ten_bit();
		soft_restart();
		fifo_fill();
		test_done();
	end
endmodule

`default_nettype wire
